// [cflc_pkg.sv]
// Package of offsets, reset values, log layout and carrier types.
package cflc_pkg;

  // Register offsets on the configuration port.
  localparam logic [7:0] OFF_LOG_SEL = 8'h47;
  localparam logic [7:0] OFF_UV_EN_LOW = 8'h48;
  localparam logic [7:0] OFF_UV_OV_EN_MID = 8'h49;
  localparam logic [7:0] OFF_OV_EN_HIGH = 8'h4a;
  localparam logic [7:0] OFF_UNLOCK = 8'h5d;
  localparam logic [7:0] OFF_FLAGS_LOW = 8'h18;
  localparam logic [7:0] OFF_FLAGS_HIGH = 8'h19;

  // Field positions.
  localparam int UNLOCK_BIT = 1;
  localparam int LOCKED_BIT = 0;

  // Values after reset: logger on with full content, nothing armed.
  localparam logic [1:0] RST_LOG_SEL = 2'h0;
  localparam logic [7:0] RST_EN = 8'h00;

  // Number of monitored inputs and width of one stored result.
  localparam int NUM_INPUTS = 12;
  localparam int RES_W = 8;

  // Nonvolatile log layout: two flag bytes, then one byte per input.
  localparam logic [7:0] LOG_BASE = 8'h01;
  localparam logic [3:0] IDX_FLAGS_FIRST = 4'h0;
  localparam logic [3:0] IDX_FLAGS_LAST = 4'h1;
  localparam logic [3:0] IDX_ADC_FIRST = 4'h2;
  localparam logic [3:0] IDX_ADC_LAST = 4'hd;

  // Logged content selection.
  typedef enum logic [1:0] {
    LOG_ALL = 2'b00,
    LOG_FLAGS = 2'b01,
    LOG_ADC = 2'b10,
    LOG_NONE = 2'b11
  } cflc_log_sel_t;

  // One access on the configuration port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cflc_cfg_req_t;

  // One byte write towards the nonvolatile memory.
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } cflc_nvm_wr_t;

endpackage

// [cflc_log_writer.sv]
// Sequencer that moves a fault snapshot into nonvolatile memory.
`timescale 1ns/1ps
module cflc_log_writer (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [11:0] flags_i,
  input wire logic [95:0] adc_i,
  input wire logic nvm_ready_i,
  output cflc_pkg::cflc_nvm_wr_t nvm_o,
  output logic busy_o,
  output logic done_o
);

  // Writer states.
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_RUN = 2'b01,
    WS_DONE = 2'b10
  } cflc_wstate_t;

  cflc_wstate_t state_r, state_nxt; // Sequencer state.
  logic [3:0] idx_r, idx_nxt; // Current log byte index.
  logic [3:0] last_r, last_nxt; // Last index for this log.
  cflc_pkg::cflc_nvm_wr_t nvm_r, nvm_nxt; // Byte write request.

  // Byte for a log index: flag bytes first, then results in input order.
  function automatic logic [7:0] log_byte(input logic [3:0] idx,
                                          input logic [11:0] fl,
                                          input logic [95:0] adc);
    logic [3:0] k;
    k = idx - cflc_pkg::IDX_ADC_FIRST;
    if (idx == cflc_pkg::IDX_FLAGS_FIRST) begin
      log_byte = fl[7:0];
    end else if (idx == cflc_pkg::IDX_FLAGS_LAST) begin
      log_byte = {4'h0, fl[11:8]};
    end else begin
      log_byte = adc[k*8 +: 8];
    end
  endfunction

  // Next-state logic; a byte is held until memory takes it.
  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    last_nxt = last_r;
    nvm_nxt = nvm_r;
    case (state_r)
      WS_IDLE: begin
        if (start_i) begin
          // Results only skip the flag bytes.
          idx_nxt = (mode_i == cflc_pkg::LOG_ADC) ?
                    cflc_pkg::IDX_ADC_FIRST : cflc_pkg::IDX_FLAGS_FIRST;
          // Flags only stop before the results.
          last_nxt = (mode_i == cflc_pkg::LOG_FLAGS) ?
                     cflc_pkg::IDX_FLAGS_LAST : cflc_pkg::IDX_ADC_LAST;
          nvm_nxt.wr = 1'b1;
          nvm_nxt.addr = cflc_pkg::LOG_BASE + {4'h0, idx_nxt};
          nvm_nxt.data = log_byte(idx_nxt, flags_i, adc_i);
          state_nxt = WS_RUN;
        end
      end
      WS_RUN: begin
        if (nvm_ready_i) begin
          if (idx_r == last_r) begin
            nvm_nxt.wr = 1'b0;
            state_nxt = WS_DONE;
          end else begin
            idx_nxt = idx_r + 4'h1;
            nvm_nxt.addr = cflc_pkg::LOG_BASE + {4'h0, idx_nxt};
            nvm_nxt.data = log_byte(idx_nxt, flags_i, adc_i);
          end
        end
      end
      WS_DONE: begin
        state_nxt = WS_IDLE;
      end
      default: begin
        state_nxt = WS_IDLE;
        nvm_nxt.wr = 1'b0;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r <= WS_IDLE;
      idx_r <= 4'h0;
      last_r <= 4'h0;
      nvm_r <= '0;
    end else begin
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      last_r <= last_nxt;
      nvm_r <= nvm_nxt;
    end
  end

  assign nvm_o = nvm_r;
  assign busy_o = (state_r == WS_RUN);
  assign done_o = (state_r == WS_DONE);

endmodule

// [cflc_top.sv]
// Critical fault enables, log content select, shutdown and log lock.
`timescale 1ns/1ps

module cflc_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input cflc_pkg::cflc_cfg_req_t cfg_i,
  input wire logic [11:0] uv_viol_i,
  input wire logic [11:0] ov_viol_i,
  input wire logic [95:0] adc_result_i,
  input wire logic [11:0] supply_en_req_i,
  input wire logic nvm_ready_i,
  output logic [7:0] cfg_rdata_o,
  output logic [11:0] supply_en_o,
  output cflc_pkg::cflc_nvm_wr_t nvm_o,
  output logic log_busy_o,
  output logic log_locked_o,
  output logic crit_fault_o
);

  // Software-visible configuration.
  logic [1:0] log_sel_r, log_sel_nxt; // Logged content select.
  logic [7:0] uv_en_low_r, uv_en_low_nxt; // Undervoltage arms 1..8.
  logic [7:0] uv_ov_en_mid_r, uv_ov_en_mid_nxt; // Mixed arms.
  logic [7:0] ov_en_high_r, ov_en_high_nxt; // Overvoltage arms 5..12.

  // Fault state.
  logic [11:0] flags_r, flags_nxt; // Per-input sticky fault flags.
  logic kill_r, kill_nxt; // Supply shutdown latch.
  logic locked_r, locked_nxt; // Log memory lock.
  logic [7:0] rdata_r, rdata_nxt; // Registered read data.
  logic [11:0] supply_r, supply_nxt; // Gated supply enables.
  logic crit_r, crit_nxt; // Registered fault pulse.

  // Snapshot handed to the writer, frozen while it runs.
  logic [11:0] snap_flags_r, snap_flags_nxt;
  logic [95:0] snap_adc_r, snap_adc_nxt;
  logic start_r, start_nxt; // One-cycle writer start.
  logic [1:0] start_mode_r, start_mode_nxt; // Content for that start.

  // Derived arm vectors and trigger terms.
  logic [11:0] uv_arm; // Undervoltage arm per input.
  logic [11:0] ov_arm; // Overvoltage arm per input.
  logic [11:0] hit; // Armed violations this cycle.
  logic crit; // Any armed violation.
  logic wr_busy; // Writer sequencing.
  logic wr_done; // Writer finished a log.

  // Address match for a write on the configuration port.
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  // Map enable registers onto per-input arms.
  assign uv_arm = {uv_ov_en_mid_r[3:0], uv_en_low_r};
  assign ov_arm = {ov_en_high_r, uv_ov_en_mid_r[7:4]};

  // Only armed comparisons count; others are dropped here.
  assign hit = (uv_viol_i & uv_arm) | (ov_viol_i & ov_arm);
  assign crit = |hit;

  // Flag update per input: an enabled violation sets, write-one clears.
  // Set wins over a clear in the same cycle so no event is lost.
  genvar g;
  generate
    for (g = 0; g < cflc_pkg::NUM_INPUTS; g++) begin : g_flag
      logic clr;
      assign clr = cfg_i.wr &&
        (g < 8 ? reg_hit(cfg_i.addr, cflc_pkg::OFF_FLAGS_LOW) &&
                 cfg_i.wdata[g % 8] :
                 reg_hit(cfg_i.addr, cflc_pkg::OFF_FLAGS_HIGH) &&
                 cfg_i.wdata[g % 8]);
      always_comb begin
        flags_nxt[g] = flags_r[g];
        if (hit[g]) begin
          flags_nxt[g] = 1'b1;
        end else if (clr) begin
          flags_nxt[g] = 1'b0;
        end
      end
    end
  endgenerate

  // Configuration writes.
  always_comb begin
    log_sel_nxt = log_sel_r;
    uv_en_low_nxt = uv_en_low_r;
    uv_ov_en_mid_nxt = uv_ov_en_mid_r;
    ov_en_high_nxt = ov_en_high_r;
    if (cfg_i.wr) begin
      if (reg_hit(cfg_i.addr, cflc_pkg::OFF_LOG_SEL)) begin
        // Upper bits are not stored and so cannot steer anything.
        log_sel_nxt = cfg_i.wdata[1:0];
      end
      if (reg_hit(cfg_i.addr, cflc_pkg::OFF_UV_EN_LOW)) begin
        uv_en_low_nxt = cfg_i.wdata;
      end
      if (reg_hit(cfg_i.addr, cflc_pkg::OFF_UV_OV_EN_MID)) begin
        uv_ov_en_mid_nxt = cfg_i.wdata;
      end
      if (reg_hit(cfg_i.addr, cflc_pkg::OFF_OV_EN_HIGH)) begin
        ov_en_high_nxt = cfg_i.wdata;
      end
    end
  end

  // Read data: registered one cycle after the read strobe.
  always_comb begin
    rdata_nxt = rdata_r;
    if (cfg_i.rd) begin
      case (cfg_i.addr)
        cflc_pkg::OFF_LOG_SEL: rdata_nxt = {6'h00, log_sel_r};
        cflc_pkg::OFF_UV_EN_LOW: rdata_nxt = uv_en_low_r;
        cflc_pkg::OFF_UV_OV_EN_MID: rdata_nxt = uv_ov_en_mid_r;
        cflc_pkg::OFF_OV_EN_HIGH: rdata_nxt = ov_en_high_r;
        cflc_pkg::OFF_FLAGS_LOW: rdata_nxt = flags_r[7:0];
        cflc_pkg::OFF_FLAGS_HIGH: rdata_nxt = {4'h0, flags_r[11:8]};
        cflc_pkg::OFF_UNLOCK: rdata_nxt = {7'h00, locked_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Shutdown latch: any armed fault kills every supply enable. It is
  // released only once the sequencer has dropped all requests, so a
  // supply never glitches back on while the request is still high.
  always_comb begin
    kill_nxt = kill_r;
    if (crit) begin
      kill_nxt = 1'b1;
    end else if (supply_en_req_i == 12'h000) begin
      kill_nxt = 1'b0;
    end
    crit_nxt = crit;
    // The fault cycle itself already forces outputs low.
    supply_nxt = (kill_r || crit) ? 12'h000 : supply_en_req_i;
  end

  // Log start: only when unlocked, idle and content is selected.
  // A fault during a running log is not logged again; the snapshot
  // must stay frozen until the last byte is taken.
  always_comb begin
    start_nxt = 1'b0;
    start_mode_nxt = start_mode_r;
    snap_flags_nxt = snap_flags_r;
    snap_adc_nxt = snap_adc_r;
    if (crit && !locked_r && !wr_busy && !start_r) begin
      if (log_sel_r != cflc_pkg::LOG_NONE) begin
        start_nxt = 1'b1;
        start_mode_nxt = log_sel_r;
        snap_flags_nxt = hit;
        snap_adc_nxt = adc_result_i;
      end
    end
  end

  // Lock: set by a finished log, cleared by writing the unlock bit.
  // A log finishing in the unlock cycle keeps the memory locked.
  always_comb begin
    locked_nxt = locked_r;
    if (wr_done) begin
      locked_nxt = 1'b1;
    end else if (cfg_i.wr && reg_hit(cfg_i.addr, cflc_pkg::OFF_UNLOCK) &&
                 cfg_i.wdata[cflc_pkg::UNLOCK_BIT]) begin
      locked_nxt = 1'b0;
    end
  end

  // All registers of the block.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      log_sel_r <= cflc_pkg::RST_LOG_SEL;
      uv_en_low_r <= cflc_pkg::RST_EN;
      uv_ov_en_mid_r <= cflc_pkg::RST_EN;
      ov_en_high_r <= cflc_pkg::RST_EN;
      flags_r <= 12'h000;
      kill_r <= 1'b0;
      locked_r <= 1'b0;
      rdata_r <= 8'h00;
      supply_r <= 12'h000;
      crit_r <= 1'b0;
      snap_flags_r <= 12'h000;
      snap_adc_r <= 96'h0;
      start_r <= 1'b0;
      start_mode_r <= cflc_pkg::RST_LOG_SEL;
    end else begin
      log_sel_r <= log_sel_nxt;
      uv_en_low_r <= uv_en_low_nxt;
      uv_ov_en_mid_r <= uv_ov_en_mid_nxt;
      ov_en_high_r <= ov_en_high_nxt;
      flags_r <= flags_nxt;
      kill_r <= kill_nxt;
      locked_r <= locked_nxt;
      rdata_r <= rdata_nxt;
      supply_r <= supply_nxt;
      crit_r <= crit_nxt;
      snap_flags_r <= snap_flags_nxt;
      snap_adc_r <= snap_adc_nxt;
      start_r <= start_nxt;
      start_mode_r <= start_mode_nxt;
    end
  end

  // Byte sequencer for the nonvolatile log.
  cflc_log_writer u_writer (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .start_i(start_r),
    .mode_i(start_mode_r),
    .flags_i(snap_flags_r),
    .adc_i(snap_adc_r),
    .nvm_ready_i(nvm_ready_i),
    .nvm_o(nvm_o),
    .busy_o(wr_busy),
    .done_o(wr_done)
  );

  assign cfg_rdata_o = rdata_r;
  assign supply_en_o = supply_r;
  assign log_busy_o = wr_busy;
  assign log_locked_o = locked_r;
  assign crit_fault_o = crit_r;

endmodule

// [cflc_top_chk.sv]
// Checker of port timing for the critical fault log block.
`timescale 1ns/1ps
module cflc_top_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input cflc_pkg::cflc_cfg_req_t cfg_i,
  input wire logic [11:0] uv_viol_i,
  input wire logic [11:0] ov_viol_i,
  input wire logic nvm_ready_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [11:0] supply_en_o,
  input cflc_pkg::cflc_nvm_wr_t nvm_o,
  input wire logic log_busy_o,
  input wire logic log_locked_o,
  input wire logic crit_fault_o
);
  // One clock domain, so one clocking and one disable for all.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // The fault pulse and the supply cut leave the same edge.
  a_fault_kills_supply: assert property (
    crit_fault_o |-> supply_en_o == 12'h000)
    else $error("supplies still on during a critical fault");
  // A fault pulse always follows a violation one cycle earlier.
  a_fault_has_cause: assert property (
    crit_fault_o |-> $past(|(uv_viol_i | ov_viol_i)))
    else $error("critical fault without any violation");
  // A byte waits unchanged until memory takes it.
  a_byte_held: assert property (
    nvm_o.wr && !nvm_ready_i |=> nvm_o.wr && $stable(nvm_o))
    else $error("log byte changed before it was accepted");
  // Log bytes stay inside the log area.
  a_log_addr_range: assert property (
    nvm_o.wr |-> nvm_o.addr inside {[8'h01:8'h0e]})
    else $error("log byte outside the log area");
  // Nothing is written while the memory is locked.
  a_locked_no_write: assert property (
    log_locked_o |-> !nvm_o.wr)
    else $error("log memory written while locked");
  // Writing the unlock bit frees the memory on the next cycle.
  a_unlock_clears: assert property (
    cfg_i.wr && cfg_i.addr == cflc_pkg::OFF_UNLOCK &&
    cfg_i.wdata[1] && log_locked_o |=> !log_locked_o)
    else $error("unlock write did not clear the lock");
  // A finished log locks the memory shortly after.
  a_lock_after_log: assert property (
    $fell(log_busy_o) |-> ##[0:3] log_locked_o)
    else $error("finished log did not lock the memory");
  // The unused select bits always read back as zero.
  a_sel_pad_zero: assert property (
    cfg_i.rd && cfg_i.addr == cflc_pkg::OFF_LOG_SEL |=>
    cfg_rdata_o[7:2] == 6'h00)
    else $error("unused select bits read nonzero");
  // Main scenarios reached by the bench.
  c_lock: cover property ($rose(log_locked_o));
  c_fault: cover property (crit_fault_o);
  c_stall: cover property (nvm_o.wr && !nvm_ready_i);
endmodule

bind cflc_top cflc_top_chk cflc_top_chk_i (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .cfg_i(cfg_i), .uv_viol_i(uv_viol_i),
  .ov_viol_i(ov_viol_i), .nvm_ready_i(nvm_ready_i), .cfg_rdata_o(cfg_rdata_o),
  .supply_en_o(supply_en_o), .nvm_o(nvm_o), .log_busy_o(log_busy_o),
  .log_locked_o(log_locked_o), .crit_fault_o(crit_fault_o));

// [cflc_top_tb.sv]
// Self-checking bench for the critical fault log block.
`timescale 1ns/1ps
module cflc_top_tb;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic nvm_ready_i = 1'b0;
  cflc_pkg::cflc_cfg_req_t cfg_i = '0;
  logic [11:0] uv_viol_i = 12'h000;
  logic [11:0] ov_viol_i = 12'h000;
  logic [11:0] supply_en_req_i = 12'hfff;
  logic [95:0] adc_result_i = '0;
  logic [7:0] cfg_rdata_o;
  logic [11:0] supply_en_o;
  cflc_pkg::cflc_nvm_wr_t nvm_o;
  logic log_busy_o;
  logic log_locked_o;
  logic crit_fault_o;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] log_q[$]; // Accepted log bytes as {addr, data}.
  cflc_top cflc_top_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cfg_i(cfg_i), .uv_viol_i(uv_viol_i), .ov_viol_i(ov_viol_i),
    .adc_result_i(adc_result_i), .supply_en_req_i(supply_en_req_i),
    .nvm_ready_i(nvm_ready_i), .cfg_rdata_o(cfg_rdata_o),
    .supply_en_o(supply_en_o), .nvm_o(nvm_o), .log_busy_o(log_busy_o),
    .log_locked_o(log_locked_o), .crit_fault_o(crit_fault_o));
  always #20 ref_clk_i = ~ref_clk_i;
  // Ready toggles so that every byte after the first of a log must be held through a stall.
  always @(negedge ref_clk_i) nvm_ready_i <= cycles[0];
  // Record accepted bytes and cut a hang short.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (nvm_o.wr === 1'b1 && nvm_ready_i === 1'b1) begin
      log_q.push_back({nvm_o.addr, nvm_o.data});
    end
    if (cycles == 5000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    cfg_i.wr = 1'b1;
    cfg_i.addr = a;
    cfg_i.wdata = d;
    @(negedge ref_clk_i);
    cfg_i.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk_i);
    cfg_i.rd = 1'b1;
    cfg_i.addr = a;
    @(negedge ref_clk_i);
    cfg_i.rd = 1'b0;
    `CHK(cfg_rdata_o, e)
  endtask
  // Arm bits as one vector: undervoltage 1-12 then overvoltage 1-12.
  task automatic arm(input logic [23:0] v);
    wr(cflc_pkg::OFF_UV_EN_LOW, v[7:0]);
    wr(cflc_pkg::OFF_UV_OV_EN_MID, v[15:8]);
    wr(cflc_pkg::OFF_OV_EN_HIGH, v[23:16]);
  endtask
  // One cycle of violations, then a check and a supply release.
  task automatic fault(input logic [11:0] uv, input logic [11:0] ov,
                       input logic e);
    @(negedge ref_clk_i);
    uv_viol_i = uv;
    ov_viol_i = ov;
    @(negedge ref_clk_i);
    uv_viol_i = 12'h000;
    ov_viol_i = 12'h000;
    `CHK(crit_fault_o, e)
    `CHK(supply_en_o, e ? 12'h000 : 12'hfff)
    supply_en_req_i = 12'h000;
    @(negedge ref_clk_i);
    supply_en_req_i = 12'hfff;
  endtask
  // Expected log byte j for content mode m.
  function automatic logic [15:0] exp_byte(input int m, input int j);
    int idx;
    logic [7:0] d;
    idx = (m == 2) ? j + 2 : j;
    d = (idx == 0) ? 8'h01 : (idx == 1) ? 8'h00 : 8'h10 + 8'(idx - 2);
    return {8'h01 + 8'(idx), d};
  endfunction
  initial begin
    for (int k = 0; k < 12; k++) adc_result_i[8*k +: 8] = 8'h10 + 8'(k);
    repeat (2) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    rd(cflc_pkg::OFF_LOG_SEL, 8'h00);
    rd(cflc_pkg::OFF_UV_EN_LOW, 8'h00);
    rd(cflc_pkg::OFF_UV_OV_EN_MID, 8'h00);
    rd(cflc_pkg::OFF_OV_EN_HIGH, 8'h00);
    wr(cflc_pkg::OFF_LOG_SEL, 8'hff);
    rd(cflc_pkg::OFF_LOG_SEL, 8'h03);
    rd(8'h50, 8'h00);
    fault(12'hfff, 12'hfff, 1'b0);
    rd(cflc_pkg::OFF_FLAGS_LOW, 8'h00);
    // Each arm bit alone; the other type and neighbours must not fire.
    for (int i = 0; i < 24; i++) begin
      arm(24'h000001 << i);
      if (i < 12) begin
        fault(~(12'h001 << i), 12'hfff, 1'b0);
        fault(12'h001 << i, 12'h000, 1'b1);
      end else begin
        fault(12'hfff, ~(12'h001 << (i - 12)), 1'b0);
        fault(12'h000, 12'h001 << (i - 12), 1'b1);
      end
    end
    rd(cflc_pkg::OFF_OV_EN_HIGH, 8'h80);
    `CHK(log_q.size(), 0)
    `CHK(log_busy_o, 1'b0)
    rd(cflc_pkg::OFF_FLAGS_HIGH, 8'h0f);
    wr(cflc_pkg::OFF_FLAGS_LOW, 8'hff);
    wr(cflc_pkg::OFF_FLAGS_HIGH, 8'h0f);
    arm(24'h000001);
    // Logging modes; a second fault while locked must not log.
    for (int m = 0; m < 3; m++) begin
      log_q.delete();
      wr(cflc_pkg::OFF_LOG_SEL, 8'(m));
      fault(12'h001, 12'h000, 1'b1);
      `CHK(log_busy_o, 1'b1)
      for (int t = 0; t < 100 && log_locked_o !== 1'b1; t++) begin
        @(negedge ref_clk_i);
      end
      `CHK(log_locked_o, 1'b1)
      `CHK(log_busy_o, 1'b0)
      fault(12'h001, 12'h000, 1'b1);
      repeat (10) @(negedge ref_clk_i);
      `CHK(log_q.size(), (m == 0) ? 14 : (m == 1) ? 2 : 12)
      foreach (log_q[j]) `CHK(log_q[j], exp_byte(m, j))
      wr(cflc_pkg::OFF_UNLOCK, 8'h02);
      `CHK(log_locked_o, 1'b0)
    end
    rd(cflc_pkg::OFF_FLAGS_LOW, 8'h01);
    tally_and_finish();
  end
endmodule
